// [sfi_irq_aggregator.sv]
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module sfi_irq_aggregator #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire sfi_pkg::sfi_live_t live,
    output logic                   irq_out_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    localparam int IW = sfi_pkg::IDX_W;

    // live indicator bytes, laid out at their register positions
    logic [7:0] dev_live;
    logic [7:0] pll_unl_live;
    logic [7:0] pll_trm_live;
    logic [7:0] aux_live;
    logic [7:0] input_live;

    always_comb begin
        dev_live = 8'h00;
        dev_live[sfi_pkg::BIT_DEV_TRIM]     = live.device_trim_active;
        dev_live[sfi_pkg::BIT_REF_ABSENT]   = live.ref_signal_absent;
        dev_live[sfi_pkg::BIT_REF_UNLOCKED] = live.ref_unlocked;
        dev_live[sfi_pkg::BIT_BUS_TIMEOUT]  = live.bus_timeout;
        pll_unl_live = 8'h00;
        pll_unl_live[sfi_pkg::BIT_PLL_UNLOCK] = live.pll_unlock;
        pll_trm_live = 8'h00;
        pll_trm_live[sfi_pkg::BIT_PLL_TRIM] = live.pll_trim_active;
        aux_live = 8'h00;
        aux_live[sfi_pkg::BIT_AUX_CRYSTAL] = live.crystal_signal_absent;
        aux_live[sfi_pkg::BIT_AUX_FREE]    = live.free_mode;
        input_live = {live.input_freq_offset, live.input_signal_absent};
    end

    // write channel state
    sfi_pkg::sfi_wr_state_t wr_state;
    sfi_pkg::sfi_wr_state_t next_wr_state;
    logic                   aw_held;
    logic                   next_aw_held;
    logic                   w_held;
    logic                   next_w_held;
    logic [IW-1:0]          aw_idx;
    logic [IW-1:0]          next_aw_idx;
    logic [7:0]             w_byte;
    logic [7:0]             next_w_byte;
    logic                   w_lane0;
    logic                   next_w_lane0;
    logic [1:0]             bresp;
    logic [1:0]             next_bresp;
    logic                   wr_fire;
    logic                   wr_hit;

    // read channel state
    sfi_pkg::sfi_rd_state_t rd_state;
    sfi_pkg::sfi_rd_state_t next_rd_state;
    logic [31:0]            rdata;
    logic [31:0]            next_rdata;
    logic [1:0]             rresp;
    logic [1:0]             next_rresp;

    // mask registers
    logic [7:0] dev_mask;
    logic [7:0] next_dev_mask;
    logic [7:0] input_mask;
    logic [7:0] next_input_mask;
    logic [7:0] pll_mask;
    logic [7:0] next_pll_mask;
    logic [7:0] pll_trim_mask;
    logic [7:0] next_pll_trim_mask;

    // sticky flags and their clear strobes
    logic [7:0] dev_stk;
    logic [7:0] pll_unl_stk;
    logic [7:0] pll_trm_stk;
    logic [7:0] aux_stk;
    logic [7:0] input_stk;
    logic [7:0] clr_dev;
    logic [7:0] clr_pll_unl;
    logic [7:0] clr_pll_trm;
    logic [7:0] clr_aux;
    logic [7:0] clr_input;

    logic       irq_any;
    logic       next_irq_out_n;

    function automatic logic is_mapped(input logic [IW-1:0] idx);
        case (idx)
            sfi_pkg::IDX_DEV_LIVE,
            sfi_pkg::IDX_PLL_UNLK_LIVE,
            sfi_pkg::IDX_PLL_TRIM_LIVE,
            sfi_pkg::IDX_DEV_STICKY,
            sfi_pkg::IDX_PLL_UNLK_STK,
            sfi_pkg::IDX_PLL_TRIM_STK,
            sfi_pkg::IDX_DEV_MASK,
            sfi_pkg::IDX_INPUT_MASK,
            sfi_pkg::IDX_PLL_MASK,
            sfi_pkg::IDX_PLL_TRIM_MASK,
            sfi_pkg::IDX_AUX_STICKY,
            sfi_pkg::IDX_INPUT_STICKY,
            sfi_pkg::IDX_AUX_LIVE,
            sfi_pkg::IDX_INPUT_LIVE: is_mapped = 1'b1;
            default:                 is_mapped = 1'b0;
        endcase
    endfunction

    // write path: address and data are caught in either order
    assign s_axi_awready = (wr_state == sfi_pkg::WR_IDLE) && !aw_held;
    assign s_axi_wready  = (wr_state == sfi_pkg::WR_IDLE) && !w_held;
    assign s_axi_bvalid  = (wr_state == sfi_pkg::WR_RESP);
    assign s_axi_bresp   = bresp;
    assign wr_fire = (wr_state == sfi_pkg::WR_IDLE) && aw_held && w_held;
    // only byte lane 0 carries register bits
    assign wr_hit  = wr_fire && w_lane0;

    always_comb begin
        next_wr_state = wr_state;
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_aw_idx   = aw_idx;
        next_w_byte   = w_byte;
        next_w_lane0  = w_lane0;
        next_bresp    = bresp;
        case (wr_state)
            sfi_pkg::WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    next_aw_held = 1'b1;
                    next_aw_idx  = s_axi_awaddr[IW+1:2];
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    next_w_held  = 1'b1;
                    next_w_byte  = s_axi_wdata[7:0];
                    next_w_lane0 = s_axi_wstrb[0];
                end
                if (wr_fire) begin
                    next_wr_state = sfi_pkg::WR_RESP;
                    next_bresp    = is_mapped(aw_idx) ?
                                    sfi_pkg::RESP_OKAY : sfi_pkg::RESP_SLVERR;
                end
            end
            sfi_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = sfi_pkg::WR_IDLE;
                    next_aw_held  = 1'b0;
                    next_w_held   = 1'b0;
                end
            end
            default: begin
                next_wr_state = sfi_pkg::WR_IDLE;
                next_aw_held  = 1'b0;
                next_w_held   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= sfi_pkg::WR_IDLE;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_idx   <= '0;
            w_byte   <= 8'h00;
            w_lane0  <= 1'b0;
            bresp    <= sfi_pkg::RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            aw_idx   <= next_aw_idx;
            w_byte   <= next_w_byte;
            w_lane0  <= next_w_lane0;
            bresp    <= next_bresp;
        end
    end

    // mask registers; unimplemented bits stay zero
    always_comb begin
        next_dev_mask      = dev_mask;
        next_input_mask    = input_mask;
        next_pll_mask      = pll_mask;
        next_pll_trim_mask = pll_trim_mask;
        if (wr_hit) begin
            case (aw_idx)
                sfi_pkg::IDX_DEV_MASK:
                    next_dev_mask = w_byte & sfi_pkg::IMPL_DEV_MSK;
                sfi_pkg::IDX_INPUT_MASK:
                    next_input_mask = w_byte & sfi_pkg::IMPL_INPUT;
                sfi_pkg::IDX_PLL_MASK:
                    next_pll_mask = w_byte & sfi_pkg::IMPL_PLL_MSK;
                sfi_pkg::IDX_PLL_TRIM_MASK:
                    next_pll_trim_mask = w_byte & sfi_pkg::IMPL_PLL_TRM;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dev_mask      <= sfi_pkg::MASK_RST;
            input_mask    <= sfi_pkg::MASK_RST;
            pll_mask      <= sfi_pkg::MASK_RST;
            pll_trim_mask <= sfi_pkg::MASK_RST;
        end else begin
            dev_mask      <= next_dev_mask;
            input_mask    <= next_input_mask;
            pll_mask      <= next_pll_mask;
            pll_trim_mask <= next_pll_trim_mask;
        end
    end

    // a zero written to a flag bit requests its clear
    always_comb begin
        clr_dev     = 8'h00;
        clr_pll_unl = 8'h00;
        clr_pll_trm = 8'h00;
        clr_aux     = 8'h00;
        clr_input   = 8'h00;
        if (wr_hit) begin
            case (aw_idx)
                sfi_pkg::IDX_DEV_STICKY:   clr_dev     = ~w_byte;
                sfi_pkg::IDX_PLL_UNLK_STK: clr_pll_unl = ~w_byte;
                sfi_pkg::IDX_PLL_TRIM_STK: clr_pll_trm = ~w_byte;
                sfi_pkg::IDX_AUX_STICKY:   clr_aux     = ~w_byte;
                sfi_pkg::IDX_INPUT_STICKY: clr_input   = ~w_byte;
                default: begin
                end
            endcase
        end
    end

    sfi_sticky #(.IMPL(sfi_pkg::IMPL_DEV)) u_dev_stk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .live    (dev_live),
        .clr     (clr_dev),
        .flag    (dev_stk)
    );

    sfi_sticky #(.IMPL(sfi_pkg::IMPL_PLL_UNL)) u_pll_unl_stk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .live    (pll_unl_live),
        .clr     (clr_pll_unl),
        .flag    (pll_unl_stk)
    );

    sfi_sticky #(.IMPL(sfi_pkg::IMPL_PLL_TRM)) u_pll_trm_stk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .live    (pll_trm_live),
        .clr     (clr_pll_trm),
        .flag    (pll_trm_stk)
    );

    sfi_sticky #(.IMPL(sfi_pkg::IMPL_AUX)) u_aux_stk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .live    (aux_live),
        .clr     (clr_aux),
        .flag    (aux_stk)
    );

    sfi_sticky #(.IMPL(sfi_pkg::IMPL_INPUT)) u_input_stk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .live    (input_live),
        .clr     (clr_input),
        .flag    (input_stk)
    );

    // interrupt: registered, so the pin lags the flags by one edge
    always_comb begin
        irq_any = 1'b0;
        irq_any = irq_any
                | |(dev_stk & ~dev_mask & sfi_pkg::IMPL_DEV)
                | (aux_stk[sfi_pkg::BIT_AUX_CRYSTAL]
                   & ~dev_mask[sfi_pkg::BIT_CRYS_MASK])
                | |(input_stk & ~input_mask)
                | (pll_unl_stk[sfi_pkg::BIT_PLL_UNLOCK]
                   & ~pll_mask[sfi_pkg::BIT_PLL_UNLOCK])
                | (aux_stk[sfi_pkg::BIT_AUX_FREE]
                   & ~pll_mask[sfi_pkg::BIT_FREE_MASK])
                | (pll_trm_stk[sfi_pkg::BIT_PLL_TRIM]
                   & ~pll_trim_mask[sfi_pkg::BIT_PLL_TRIM]);
        // stays low until every unmasked flag is cleared
        next_irq_out_n = ~irq_any;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= next_irq_out_n;
        end
    end

    // read path; live bytes are sampled at the read, flags as stored
    function automatic logic [7:0] read_byte(input logic [IW-1:0] idx);
        case (idx)
            sfi_pkg::IDX_DEV_LIVE:      read_byte = dev_live;
            sfi_pkg::IDX_PLL_UNLK_LIVE: read_byte = pll_unl_live;
            sfi_pkg::IDX_PLL_TRIM_LIVE: read_byte = pll_trm_live;
            sfi_pkg::IDX_DEV_STICKY:    read_byte = dev_stk;
            sfi_pkg::IDX_PLL_UNLK_STK:  read_byte = pll_unl_stk;
            sfi_pkg::IDX_PLL_TRIM_STK:  read_byte = pll_trm_stk;
            sfi_pkg::IDX_DEV_MASK:      read_byte = dev_mask;
            sfi_pkg::IDX_INPUT_MASK:    read_byte = input_mask;
            sfi_pkg::IDX_PLL_MASK:      read_byte = pll_mask;
            sfi_pkg::IDX_PLL_TRIM_MASK: read_byte = pll_trim_mask;
            sfi_pkg::IDX_AUX_STICKY:    read_byte = aux_stk;
            sfi_pkg::IDX_INPUT_STICKY:  read_byte = input_stk;
            sfi_pkg::IDX_AUX_LIVE:      read_byte = aux_live;
            sfi_pkg::IDX_INPUT_LIVE:    read_byte = input_live;
            default:                    read_byte = 8'h00;
        endcase
    endfunction

    assign s_axi_arready = (rd_state == sfi_pkg::RD_IDLE);
    assign s_axi_rvalid  = (rd_state == sfi_pkg::RD_DATA);
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

    always_comb begin
        next_rd_state = rd_state;
        next_rdata    = rdata;
        next_rresp    = rresp;
        case (rd_state)
            sfi_pkg::RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_rd_state = sfi_pkg::RD_DATA;
                    next_rdata    = {24'h000000,
                                     read_byte(s_axi_araddr[IW+1:2])};
                    next_rresp    = is_mapped(s_axi_araddr[IW+1:2]) ?
                                    sfi_pkg::RESP_OKAY : sfi_pkg::RESP_SLVERR;
                end
            end
            sfi_pkg::RD_DATA: begin
                if (s_axi_rready) begin
                    next_rd_state = sfi_pkg::RD_IDLE;
                end
            end
            default: begin
                next_rd_state = sfi_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= sfi_pkg::RD_IDLE;
            rdata    <= 32'h00000000;
            rresp    <= sfi_pkg::RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
        end
    end
endmodule

// [sfi_irq_aggregator_chk.sv]
`timescale 1ns/1ps
module sfi_irq_aggregator_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire sfi_pkg::sfi_live_t live,
    input wire logic               irq_out_n,
    input wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic [31:0]        s_axi_wdata,
    input wire logic [3:0]         s_axi_wstrb,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic [ADDR_W-1:0]  s_axi_araddr,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [1:0]         s_axi_rresp,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic any_live;
    logic wr_busy;
    assign any_live = |live;
    // awready stays low from address take to response, so it marks writes
    assign wr_busy = !s_axi_awready;
    sequence rd_at(a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(a);
    endsequence
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    dev_live_a: assert property (rd_at(4*sfi_pkg::IDX_DEV_LIVE)
        |=> s_axi_rdata == {26'h0, $past(live.bus_timeout), 1'b0,
        $past(live.ref_unlocked), $past(live.ref_signal_absent), 1'b0,
        $past(live.device_trim_active)})
        else $error("device live word wrong");
    pll_trim_a: assert property (rd_at(4*sfi_pkg::IDX_PLL_TRIM_LIVE)
        |=> s_axi_rdata == {26'h0, $past(live.pll_trim_active), 5'h0})
        else $error("pll trim live word wrong");
    pll_unlk_a: assert property (rd_at(4*sfi_pkg::IDX_PLL_UNLK_LIVE)
        |=> s_axi_rdata == {30'h0, $past(live.pll_unlock), 1'b0})
        else $error("pll unlock live word wrong");
    unmapped_rd_a: assert property (rd_at(0) |=> s_axi_rdata == 32'h0
        && s_axi_rresp == sfi_pkg::RESP_SLVERR)
        else $error("unmapped read answered wrongly");
    irq_set_a: assert property ($fell(irq_out_n)
        |-> $past(any_live, 2) || $past(wr_busy))
        else $error("interrupt asserted without cause");
    irq_rel_a: assert property ($rose(irq_out_n) |-> $past(wr_busy))
        else $error("interrupt released without software write");
    // both taken at one edge, register and bvalid set together at the next edge, bvalid seen at the one after
    wr_ans_a: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_ans_a: assert property (rd_at(s_axi_araddr) |=> s_axi_rvalid)
        else $error("read data late");
    b_refuse_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during data");
endmodule

bind sfi_irq_aggregator sfi_irq_aggregator_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// [sfi_irq_aggregator_test.sv]
`timescale 1ns/1ps
module sfi_irq_aggregator_test;
    localparam int ADDR_W = 8;
    logic aclk = 0, aresetn = 0, irq_out_n;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] fault = 0;
    sfi_pkg::sfi_live_t live;
    int n_errors = 0, cmp_count = 0, cyc = 0;

    sfi_irq_aggregator #(.ADDR_W(ADDR_W)) DUT (.*);
    sfi_src_model u_src (.*);

    always #12.5 aclk = ~aclk;

    task automatic print_verdict();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake would otherwise stall the run forever
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d,
                      input logic [3:0] st, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdw(input logic [5:0] i, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] i, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rdw(i, d, r);
        chk(d, exp);
        chk({30'h0, r}, 32'h0);
    endtask

    task automatic pulse(input int src);
        @(posedge aclk);
        fault <= 16'h1 << src;
        repeat (4) @(posedge aclk);
    endtask

    // one source: live view, sticky hold, refused clear, clear, masking
    task automatic run_src(input int src, input logic [5:0] li, si,
                           input int b, input logic [5:0] mi, input int mb);
        logic [31:0] v, m;
        logic [1:0] r;
        v = 32'h1 << b;
        m = 32'h1 << mb;
        pulse(src);
        rchk(li, v);
        chk({31'h0, irq_out_n}, 32'h0);
        wr(si, 8'h00, 4'h1, r);
        rchk(si, v);
        pulse(-1);
        rchk(li, 32'h0);
        rchk(si, v);
        chk({31'h0, irq_out_n}, 32'h0);
        wr(si, 8'h00, 4'h1, r);
        repeat (2) @(posedge aclk);
        rchk(si, 32'h0);
        chk({31'h0, irq_out_n}, 32'h1);
        wr(mi, m[7:0], 4'h1, r);
        rchk(mi, m);
        pulse(src);
        pulse(-1);
        chk({31'h0, irq_out_n}, 32'h1);
        wr(mi, 8'h00, 4'h1, r);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_out_n}, 32'h0);
        wr(si, 8'h00, 4'h1, r);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_out_n}, 32'h1);
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            rchk(6'(6'h17 + i), 32'h0);
        end
        chk({31'h0, irq_out_n}, 32'h1);
        rdw(6'h00, rd, rs);
        chk(rd, 32'h0);
        chk({30'h0, rs}, 32'h2);
        wr(6'h01, 8'hff, 4'hf, rs);
        chk({30'h0, rs}, 32'h2);
        wr(6'h17, 8'hff, 4'h0, rs);
        rchk(6'h17, 32'h0);
        run_src(15, 6'h0c, 6'h11, 0, 6'h17, 0);
        run_src(14, 6'h0c, 6'h11, 2, 6'h17, 2);
        run_src(13, 6'h0c, 6'h11, 3, 6'h17, 3);
        run_src(12, 6'h0c, 6'h11, 5, 6'h17, 5);
        run_src(11, 6'h0f, 6'h14, 5, 6'h1a, 5);
        run_src(10, 6'h0e, 6'h13, 1, 6'h19, 1);
        run_src(9, 6'h22, 6'h20, 0, 6'h17, 1);
        run_src(8, 6'h22, 6'h20, 1, 6'h19, 5);
        for (int i = 0; i < 4; i++) begin
            run_src(4 + i, 6'h23, 6'h21, i, 6'h18, i);
            run_src(i, 6'h23, 6'h21, 4 + i, 6'h18, 4 + i);
        end
        print_verdict();
    end
endmodule

// [sfi_pkg.sv]
// Contract
// - reg 0x0c bit 0 reads 1 while the device self-trim runs.
// - reg 0x0c bit 2 reads 1 while the crystal reference signal is absent.
// - reg 0x0c bit 3 reads 1 while not locked to the crystal reference.
// - reg 0x0c bit 5 reads 1 once a serial bus timeout occurred.
// - reg 0x0f bit 5 reads 1 while the pll trim sequence runs.
// - each indicator has a sticky flag, set on fault, held until cleared.
// - sticky flags at 0x11 bits 0,2,3,5 and pll trim at 0x14 bit 5.
// - writing 0 clears a sticky flag only once its indicator is gone.
// - unmasked sticky flags drive the interrupt pin; each flag is maskable.
// - pin releases only after software clears every unmasked causing flag.
// - reg 0x18 bits 3:0 mask input signal-absent flags, 1 ignores.
// - reg 0x18 bits 7:4 mask input frequency-offset flags, 1 ignores.
// - reg 0x19 bit 1 masks pll unlock, bit 5 masks free mode.
// - reg 0x1a bit 5 masks the pll trim flag.
// - reg 0x17 bits 0,1,2,3,5 mask trim, crystal, absent, unlocked, timeout.
// - every mask bit resets to 0, all sources allowed.
// - pll unlock live at 0x0e bit 1, sticky at 0x13 bit 1.
package sfi_pkg;

    localparam int IDX_W = 6;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DEV_LIVE      = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_PLL_UNLK_LIVE = 6'h0e;
    localparam logic [IDX_W-1:0] IDX_PLL_TRIM_LIVE = 6'h0f;
    localparam logic [IDX_W-1:0] IDX_DEV_STICKY    = 6'h11;
    localparam logic [IDX_W-1:0] IDX_PLL_UNLK_STK  = 6'h13;
    localparam logic [IDX_W-1:0] IDX_PLL_TRIM_STK  = 6'h14;
    localparam logic [IDX_W-1:0] IDX_DEV_MASK      = 6'h17;
    localparam logic [IDX_W-1:0] IDX_INPUT_MASK    = 6'h18;
    localparam logic [IDX_W-1:0] IDX_PLL_MASK      = 6'h19;
    localparam logic [IDX_W-1:0] IDX_PLL_TRIM_MASK = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_AUX_STICKY    = 6'h20;
    localparam logic [IDX_W-1:0] IDX_INPUT_STICKY  = 6'h21;
    localparam logic [IDX_W-1:0] IDX_AUX_LIVE      = 6'h22;
    localparam logic [IDX_W-1:0] IDX_INPUT_LIVE    = 6'h23;

    // field positions
    localparam int BIT_DEV_TRIM     = 0;
    localparam int BIT_CRYS_MASK    = 1;
    localparam int BIT_REF_ABSENT   = 2;
    localparam int BIT_REF_UNLOCKED = 3;
    localparam int BIT_BUS_TIMEOUT  = 5;
    localparam int BIT_PLL_UNLOCK   = 1;
    localparam int BIT_PLL_TRIM     = 5;
    localparam int BIT_FREE_MASK    = 5;
    localparam int BIT_AUX_CRYSTAL  = 0;
    localparam int BIT_AUX_FREE     = 1;
    localparam int INPUT_ABSENT_LO  = 0;
    localparam int INPUT_OFFSET_LO  = 4;

    // implemented bits per register
    localparam logic [7:0] IMPL_DEV     = 8'h2d;
    localparam logic [7:0] IMPL_PLL_UNL = 8'h02;
    localparam logic [7:0] IMPL_PLL_TRM = 8'h20;
    localparam logic [7:0] IMPL_AUX     = 8'h03;
    localparam logic [7:0] IMPL_INPUT   = 8'hff;
    localparam logic [7:0] IMPL_DEV_MSK = 8'h2f;
    localparam logic [7:0] IMPL_PLL_MSK = 8'h22;

    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] STICKY_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       device_trim_active;
        logic       ref_signal_absent;
        logic       ref_unlocked;
        logic       bus_timeout;
        logic       pll_trim_active;
        logic       pll_unlock;
        logic       crystal_signal_absent;
        logic       free_mode;
        logic [3:0] input_signal_absent;
        logic [3:0] input_freq_offset;
    } sfi_live_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } sfi_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } sfi_rd_state_t;

endpackage

// [sfi_src_model.sv]
`timescale 1ns/1ps
module sfi_src_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] fault,
    output sfi_pkg::sfi_live_t live
);
    // monitors update just after the edge, like the real fault logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            live <= '0;
        end else begin
            live <= sfi_pkg::sfi_live_t'(fault);
        end
    end
endmodule

// [sfi_sticky.sv]
`timescale 1ns/1ps
module sfi_sticky #(
    parameter logic [7:0] IMPL = 8'hff
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] live,
    input  wire logic [7:0] clr,
    output logic      [7:0] flag
);
    logic [7:0] next_flag;

    // a live fault always wins, so a clear racing a new fault loses
    always_comb begin
        next_flag = ((flag & ~(clr & ~live)) | live) & IMPL;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= sfi_pkg::STICKY_RST;
        end else begin
            flag <= next_flag;
        end
    end
endmodule
